// ==== design/srx_pkg.sv ====
// Purpose: shared constants of the receiver start-up and clock source block
// Assumes: 100 MHz system clock, 32-bit command data
// Notes: register index sits above the two chip address bits of the address
package srx_pkg;
  // ==========================================================
  // command port layout
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int CHIP_LSB = 0;
  localparam int REG_LSB = 2;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_FS_PERIOD = 4'h2;
  // ==========================================================
  // control register fields
  localparam int VCO_RUN_BIT = 0;
  localparam int XTAL_FREQ_BIT = 1;
  localparam int FS_MASK_BIT = 2;
  localparam int AMP_OP_LSB = 3;
  localparam int XDIV_LSB = 5;
  localparam int IN_SEL_LSB = 7;
  localparam int CLK_SRC_BIT = 10;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h001;
  // ==========================================================
  // field encodings
  localparam logic [1:0] AMP_CONT = 2'h0;
  localparam logic [1:0] AMP_AUTO = 2'h1;
  localparam logic [1:0] XDIV_1 = 2'h0;
  localparam logic [1:0] XDIV_2 = 2'h1;
  localparam logic [1:0] XDIV_4 = 2'h2;
  localparam logic [1:0] XDIV_MUTE = 2'h3;
  localparam logic [2:0] IN_NONE = 3'h7;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_US = 10000;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int FS_W = 16;
  typedef enum logic [1:0] {FS_IDLE, FS_FIRST, FS_CHECK, FS_STABLE} srx_fs_t;
endpackage

// ==== design/srx_clk_div.sv ====
// Purpose: divider that turns the system clock into a square wave output
// Assumes: one clock; the output toggles on a one-cycle enable
// Notes: ratio 0 mutes the output low
`timescale 1ns/1ps
`default_nettype none
module srx_clk_div #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] ratio,
  // output
  output logic wave
);
  // ==========================================================
  // ratio 1,2,3 enables every cycle, on prescaler bit 0, on bits 1:0 both high
  logic [W-1:0] cnt_q;
  logic tick;
  initial begin
    if (W < 3) $error("srx_clk_div needs W of at least 3");
  end
  // free-running prescaler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  always_comb begin
    case (ratio)
      2'h1: tick = 1'b1;
      2'h2: tick = cnt_q[0];
      2'h3: tick = &cnt_q[1:0];
      default: tick = 1'b0;
    endcase
  end
  // toggle on each enable, parked low when muted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else if (ratio == 2'h0) begin
      wave <= 1'b0;
    end else if (tick) begin
      wave <= ~wave;
    end
  end
endmodule
`default_nettype wire

// ==== design/srx_clock_ctrl.sv ====
// Purpose: strap capture, command decode and clock source control
// Assumes: all pins but ARST_N synchronous to CLK; PLL lock and fs edge come from analog
// Notes: crystal output wave stands for the crystal clock scaled to CLK
`timescale 1ns/1ps
`default_nettype none
module srx_clock_ctrl #(
  parameter int SETTLE_CYCLES = srx_pkg::SETTLE_CYC,
  parameter int FS_WIDTH = srx_pkg::FS_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SYS_RESET_N,
  // straps
  input wire logic ADDR_LOW_STRAP,
  input wire logic ADDR_HIGH_STRAP,
  input wire logic ROLE_STRAP,
  input wire logic GPIO_DIR_STRAP,
  // command port
  input wire logic [srx_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [srx_pkg::DATA_W-1:0] CMD_WDATA,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  output logic [srx_pkg::DATA_W-1:0] CMD_RDATA,
  // analog status
  input wire logic PLL_LOCK_RAW,
  input wire logic FS_EDGE,
  // clock pins
  output logic R_BIT_CLOCK_OE,
  output logic R_FRAME_CLOCK_OE,
  output logic R_MASTER_CLOCK_OE,
  output logic [3:0] GPIO_OE,
  output logic CRYSTAL_CLOCK_OUT,
  // clock source control
  output logic VCO_RUN,
  output logic AMP_RUN,
  output logic SRC_CRYSTAL,
  output logic CLOCK_MUTE,
  output logic LOCK_ERROR_OUT
);
  import srx_pkg::*;
  // ==========================================================
  // parameter checks
  // a settle count of zero would leave no error window after restart
  initial begin
    if (SETTLE_CYCLES < 1) $error("SETTLE_CYCLES must be positive");
    if (FS_WIDTH < 4 || FS_WIDTH > DATA_W) $error("FS_WIDTH out of range");
  end
  localparam int SW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);
  // ==========================================================
  // reset release through two flops
  // async assert, sync release, so no flop sees a release edge near CLK
  // the core counts from the third edge after ARST_N rises
  logic arst_s1_q;
  logic arst_s2_q;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arst_s1_q <= 1'b0;
      arst_s2_q <= 1'b0;
    end else begin
      arst_s1_q <= 1'b1;
      arst_s2_q <= arst_s1_q;
    end
  end
  // system reset pin also holds the core
  logic run;
  assign run = SYS_RESET_N;
  // ==========================================================
  // strap capture: sampled while the pin is low, frozen on release
  // the last level before release wins; a floating strap pin
  // would leave the chip address undefined and the part unreachable
  logic [1:0] chip_addr_q;
  logic slave_q;
  logic gpio_out_q;
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      chip_addr_q <= 2'h0;
      slave_q <= 1'b0;
      gpio_out_q <= 1'b0;
    end else if (!run) begin
      chip_addr_q <= {ADDR_HIGH_STRAP, ADDR_LOW_STRAP};
      slave_q <= ROLE_STRAP;
      gpio_out_q <= GPIO_DIR_STRAP;
    end
  end
  // ==========================================================
  // command decode
  // index bits sit above the chip bits; a foreign chip address
  // leaves both the control write and the read data untouched
  logic chip_hit;
  logic [3:0] reg_idx;
  // low address bit is the first sent, so it sits at the lowest position
  assign chip_hit = CMD_ADDR[CHIP_LSB +: 2] == chip_addr_q;
  assign reg_idx = CMD_ADDR[REG_LSB +: 4];
  // control register
  // held at its reset word while the system reset pin is low
  logic [CTRL_W-1:0] ctrl_q;
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      ctrl_q <= CTRL_RESET;
    end else if (!run) begin
      ctrl_q <= CTRL_RESET;
    end else if (CMD_WR && chip_hit && reg_idx == REG_CTRL) begin
      ctrl_q <= CMD_WDATA[CTRL_W-1:0];
    end
  end
  logic vco_run_ctrl;
  logic crystal_freq_select;
  logic fs_change_error_mask;
  logic [1:0] osc_amp_operation;
  logic [1:0] crystal_out_divider;
  logic [2:0] input_select;
  logic clock_source_select;
  assign vco_run_ctrl = ctrl_q[VCO_RUN_BIT];
  assign crystal_freq_select = ctrl_q[XTAL_FREQ_BIT];
  assign fs_change_error_mask = ctrl_q[FS_MASK_BIT];
  assign osc_amp_operation = ctrl_q[AMP_OP_LSB +: 2];
  assign crystal_out_divider = ctrl_q[XDIV_LSB +: 2];
  assign input_select = ctrl_q[IN_SEL_LSB +: 3];
  assign clock_source_select = ctrl_q[CLK_SRC_BIT];
  // ==========================================================
  // lock qualification: no input or stopped VCO means unlocked
  // the raw analog level cannot be trusted in either case,
  // so both gate it before anything switches on lock
  logic locked;
  assign locked = PLL_LOCK_RAW && vco_run_ctrl && input_select != IN_NONE;
  // amplifier state: auto mode stops it while locked
  // codes 2 and 3 stop the amplifier outright
  logic amp_run_d;
  always_comb begin
    case (osc_amp_operation)
      AMP_CONT: amp_run_d = 1'b1;
      AMP_AUTO: amp_run_d = !locked;
      default: amp_run_d = 1'b0;
    endcase
  end
  // source: select 0 follows lock, 1 forces crystal, both systems at once
  // one select feeds R and S systems, so they can never disagree
  logic src_xtal_d;
  assign src_xtal_d = clock_source_select || !locked;
  // ==========================================================
  // pin direction and source outputs
  // pins are directed one edge after the strap capture
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      R_BIT_CLOCK_OE <= 1'b0;
      R_FRAME_CLOCK_OE <= 1'b0;
      R_MASTER_CLOCK_OE <= 1'b0;
      GPIO_OE <= 4'h0;
    end else begin
      R_BIT_CLOCK_OE <= !slave_q;
      R_FRAME_CLOCK_OE <= !slave_q;
      R_MASTER_CLOCK_OE <= 1'b1;
      GPIO_OE <= {4{gpio_out_q}};
    end
  end
  // source, amplifier and mute, updated together
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      VCO_RUN <= 1'b1;
      AMP_RUN <= 1'b1;
      SRC_CRYSTAL <= 1'b1;
      CLOCK_MUTE <= 1'b0;
    end else if (!run) begin
      VCO_RUN <= 1'b1;
      AMP_RUN <= 1'b1;
      SRC_CRYSTAL <= 1'b1;
      CLOCK_MUTE <= 1'b0;
    end else begin
      VCO_RUN <= vco_run_ctrl;
      AMP_RUN <= amp_run_d;
      SRC_CRYSTAL <= src_xtal_d;
      // crystal source with a stopped amplifier has nothing to give
      CLOCK_MUTE <= src_xtal_d && !amp_run_d;
    end
  end
  // ==========================================================
  // crystal clock output divider
  // a stopped amplifier gives no crystal clock, so the divider parks
  logic [1:0] div_ratio;
  logic div_wave;
  always_comb begin
    case (crystal_out_divider)
      XDIV_1: div_ratio = 2'h1;
      XDIV_2: div_ratio = 2'h2;
      XDIV_4: div_ratio = 2'h3;
      default: div_ratio = 2'h0;
    endcase
    if (!AMP_RUN) div_ratio = 2'h0;
  end
  srx_clk_div #(.W(3)) u_xdiv (
    .clk(CLK),
    .rst_n(arst_s2_q),
    .ratio(div_ratio),
    .wave(div_wave)
  );
  // extra flop keeps the pin straight from a register
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      CRYSTAL_CLOCK_OUT <= 1'b0;
    end else begin
      CRYSTAL_CLOCK_OUT <= div_wave;
    end
  end
  // ==========================================================
  // amplifier restart detect
  // reset value matches AMP_RUN after reset, so no false restart
  logic amp_prev_q;
  logic amp_restart;
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      amp_prev_q <= 1'b1;
    end else begin
      amp_prev_q <= AMP_RUN;
    end
  end
  assign amp_restart = AMP_RUN && !amp_prev_q;
  // settle window after restart
  // long count at full rate; simulation shortens it by parameter
  logic [SW-1:0] settle_q;
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      settle_q <= '0;
    end else if (!run) begin
      settle_q <= '0;
    end else if (amp_restart) begin
      settle_q <= SETTLE_LOAD;
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end
  // ==========================================================
  // fs period measurement on crystal clock; only valid while amp runs
  // equal periods on two edges in a row mark the rate as stable
  // a single odd frame spacing shows as a change until the next pair
  srx_fs_t fs_state_q;
  logic [FS_WIDTH-1:0] fs_cnt_q;
  logic [FS_WIDTH-1:0] fs_last_q;
  logic fs_changed_q;
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      fs_state_q <= FS_IDLE;
      fs_cnt_q <= '0;
      fs_last_q <= '0;
      fs_changed_q <= 1'b0;
    end else if (!run || amp_restart || !AMP_RUN) begin
      // old value is dropped so a fresh pair must agree again
      fs_state_q <= FS_IDLE;
      fs_cnt_q <= '0;
      fs_last_q <= '0;
      fs_changed_q <= 1'b0;
    end else begin
      if (fs_cnt_q != '1) fs_cnt_q <= fs_cnt_q + 1'b1;
      if (FS_EDGE) begin
        fs_cnt_q <= '0;
        case (fs_state_q)
          FS_IDLE: fs_state_q <= FS_FIRST;
          FS_FIRST: begin
            fs_last_q <= fs_cnt_q;
            fs_state_q <= FS_CHECK;
          end
          default: begin
            fs_last_q <= fs_cnt_q;
            fs_changed_q <= fs_cnt_q != fs_last_q;
            fs_state_q <= (fs_cnt_q == fs_last_q) ? FS_STABLE : FS_CHECK;
          end
        endcase
      end
    end
  end
  // ==========================================================
  // lock error pin: high in reset, on unlock, while settling or fs change
  // trade-off: settling is a fixed count, not a measured oscillation
  logic fs_busy;
  assign fs_busy = fs_state_q != FS_STABLE && fs_state_q != FS_IDLE;
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      LOCK_ERROR_OUT <= 1'b1;
    end else if (!run) begin
      LOCK_ERROR_OUT <= 1'b1;
    end else begin
      // lock is reported whatever source is in use
      LOCK_ERROR_OUT <= !locked || settle_q != '0 ||
                        (fs_busy && amp_prev_q != AMP_RUN) ||
                        (fs_changed_q && !fs_change_error_mask);
    end
  end
  // ==========================================================
  // read data, one cycle after the strobe; other cycles read zero
  // strobes are one cycle long, so the value stands for one cycle
  logic [DATA_W-1:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (!CMD_RD || !chip_hit) begin
      rd_d = '0;
    end else if (reg_idx == REG_CTRL) begin
      rd_d[CTRL_W-1:0] = ctrl_q;
    end else if (reg_idx == REG_STATUS) begin
      rd_d[0] = locked;
      rd_d[1] = SRC_CRYSTAL;
      rd_d[2] = AMP_RUN;
      rd_d[3] = CLOCK_MUTE;
      rd_d[4] = LOCK_ERROR_OUT;
      rd_d[5] = settle_q != '0;
      rd_d[6] = fs_state_q == FS_STABLE;
      rd_d[7] = slave_q;
      rd_d[8] = gpio_out_q;
      rd_d[10:9] = chip_addr_q;
      rd_d[11] = crystal_freq_select;
    end else if (reg_idx == REG_FS_PERIOD) begin
      rd_d[FS_WIDTH-1:0] = fs_last_q;
    end
  end
  always_ff @(posedge CLK or negedge arst_s2_q) begin
    if (!arst_s2_q) begin
      CMD_RDATA <= '0;
    end else begin
      CMD_RDATA <= rd_d;
    end
  end
endmodule
`default_nettype wire

// ==== verification/srx_clock_monitor.sv ====
// Purpose: port checker for the strap and clock source block
// Assumes: one clock domain, ARST_N released through the block's own flops
// Notes: live waits out the reset synchroniser before anything is judged
`timescale 1ns/1ps
`default_nettype none
module srx_clock_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SYS_RESET_N,
  // straps and command
  input wire logic ROLE_STRAP,
  input wire logic GPIO_DIR_STRAP,
  input wire logic CMD_RD,
  input wire logic [srx_pkg::DATA_W-1:0] CMD_RDATA,
  // analog status and outputs
  input wire logic PLL_LOCK_RAW,
  input wire logic R_BIT_CLOCK_OE,
  input wire logic R_FRAME_CLOCK_OE,
  input wire logic R_MASTER_CLOCK_OE,
  input wire logic [3:0] GPIO_OE,
  input wire logic CRYSTAL_CLOCK_OUT,
  input wire logic VCO_RUN,
  input wire logic AMP_RUN,
  input wire logic SRC_CRYSTAL,
  input wire logic CLOCK_MUTE,
  input wire logic LOCK_ERROR_OUT
);
  logic [2:0] up_q;
  logic live;
  // ==========================================
  // cycles since reset release, saturating
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  assign live = (up_q == 3'h7);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // ==========================================
  // assertions
  master_oe_a: assert property (live |-> R_MASTER_CLOCK_OE)
    else $error("master clock pin not driven");
  role_oe_a: assert property (live && !SYS_RESET_N && $past(SYS_RESET_N, 3) == 1'b0
    && ROLE_STRAP == $past(ROLE_STRAP, 3) |-> R_BIT_CLOCK_OE == !ROLE_STRAP)
    else $error("bit clock direction differs from role strap");
  frame_oe_a: assert property (live |-> R_FRAME_CLOCK_OE == R_BIT_CLOCK_OE)
    else $error("frame and bit clock directions differ");
  gpio_oe_a: assert property (live && !SYS_RESET_N && $past(SYS_RESET_N, 3) == 1'b0
    && GPIO_DIR_STRAP == $past(GPIO_DIR_STRAP, 3) |-> GPIO_OE == {4{GPIO_DIR_STRAP}})
    else $error("general pin direction differs from strap");
  rd_idle_a: assert property (live && !$past(CMD_RD) |-> CMD_RDATA == '0)
    else $error("read data outside its cycle");
  unlock_src_a: assert property ((live && !PLL_LOCK_RAW) [*3] |-> SRC_CRYSTAL && LOCK_ERROR_OUT)
    else $error("unlocked but not on crystal or no error");
  vco_off_a: assert property ((live && !VCO_RUN) [*3] |-> SRC_CRYSTAL)
    else $error("stopped oscillator still used as source");
  amp_stop_a: assert property ((live && !AMP_RUN) [*3] |-> !CRYSTAL_CLOCK_OUT)
    else $error("crystal output toggles with amplifier stopped");
  settle_err_a: assert property (live && $rose(AMP_RUN) |-> ##2 LOCK_ERROR_OUT [*8])
    else $error("no error during amplifier settling");
  sys_reset_a: assert property ((live && !SYS_RESET_N) [*2] |-> LOCK_ERROR_OUT && VCO_RUN && AMP_RUN)
    else $error("system reset does not hold defaults");
  // main scenarios reached
  cover property (live && $rose(AMP_RUN));
  cover property (live && CLOCK_MUTE);
  cover property (live && !SRC_CRYSTAL);
endmodule
bind srx_clock_ctrl srx_clock_monitor u_mon (
  .CLK(CLK), .ARST_N(ARST_N), .SYS_RESET_N(SYS_RESET_N),
  .ROLE_STRAP(ROLE_STRAP), .GPIO_DIR_STRAP(GPIO_DIR_STRAP),
  .CMD_RD(CMD_RD), .CMD_RDATA(CMD_RDATA), .PLL_LOCK_RAW(PLL_LOCK_RAW),
  .R_BIT_CLOCK_OE(R_BIT_CLOCK_OE), .R_FRAME_CLOCK_OE(R_FRAME_CLOCK_OE),
  .R_MASTER_CLOCK_OE(R_MASTER_CLOCK_OE), .GPIO_OE(GPIO_OE),
  .CRYSTAL_CLOCK_OUT(CRYSTAL_CLOCK_OUT), .VCO_RUN(VCO_RUN), .AMP_RUN(AMP_RUN),
  .SRC_CRYSTAL(SRC_CRYSTAL), .CLOCK_MUTE(CLOCK_MUTE), .LOCK_ERROR_OUT(LOCK_ERROR_OUT)
);
`default_nettype wire

// ==== verification/srx_far_model.sv ====
// Purpose: analog side model: frame pulses and loop lock level
// Assumes: frames at a steady rate of one every 16 clocks
// Notes: lock is only claimed while frames arrive, as a real loop would
`timescale 1ns/1ps
`default_nettype none
module srx_far_model (
  // clock
  input wire logic clk,
  // bench controls
  input wire logic lock_req,
  input wire logic frames_on,
  // analog status
  output logic pll_lock_raw = 1'b0,
  output logic fs_edge = 1'b0
);
  logic [3:0] cnt_q = 4'h0;
  // ==========================================
  // one pulse per frame, fixed spacing so the rate measurement settles
  always_ff @(posedge clk) begin
    cnt_q <= frames_on ? cnt_q + 4'h1 : 4'h0;
    fs_edge <= frames_on && (cnt_q == 4'hf);
  end
  // no lock without input frames
  always_ff @(posedge clk) begin
    pll_lock_raw <= lock_req && frames_on;
  end
endmodule
`default_nettype wire

// ==== verification/srx_bench.sv ====
// Purpose: self-checking bench of the strap and clock source block
// Assumes: settle count shortened to 20 clocks
// Notes: strap moves after release must not reach the outputs
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_strap_and_clock_source_bench;
  import srx_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sys_n = 1'b0;
  logic a_lo = 1'b0;
  logic a_hi = 1'b0;
  logic role = 1'b0;
  logic gdir = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic lock_req = 1'b0;
  logic frames_on = 1'b0;
  logic lock_raw, fs_edge, bck_oe, lrck_oe, mck_oe, xtal_out;
  logic vco_run, amp_run, src_xtal, clk_mute, lock_err;
  logic [3:0] gpio_oe;
  logic [1:0] chip = 2'h0;
  logic [31:0] d;
  logic prev;
  int n;
  int fails = 0;
  int total_checks = 0;
  // ==========================================
  // clock, model and design
  always #5 clk = ~clk;
  srx_far_model u_far (.clk(clk), .lock_req(lock_req), .frames_on(frames_on),
    .pll_lock_raw(lock_raw), .fs_edge(fs_edge));
  srx_clock_ctrl #(.SETTLE_CYCLES(20)) dut (.CLK(clk), .ARST_N(arst_n),
    .SYS_RESET_N(sys_n), .ADDR_LOW_STRAP(a_lo), .ADDR_HIGH_STRAP(a_hi),
    .ROLE_STRAP(role), .GPIO_DIR_STRAP(gdir), .CMD_ADDR(addr), .CMD_WDATA(wdata),
    .CMD_WR(wr_s), .CMD_RD(rd_s), .CMD_RDATA(rdata), .PLL_LOCK_RAW(lock_raw),
    .FS_EDGE(fs_edge), .R_BIT_CLOCK_OE(bck_oe), .R_FRAME_CLOCK_OE(lrck_oe),
    .R_MASTER_CLOCK_OE(mck_oe), .GPIO_OE(gpio_oe), .CRYSTAL_CLOCK_OUT(xtal_out),
    .VCO_RUN(vco_run), .AMP_RUN(amp_run), .SRC_CRYSTAL(src_xtal),
    .CLOCK_MUTE(clk_mute), .LOCK_ERROR_OUT(lock_err));
  // ==========================================
  // access and compare tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] v);
    @(posedge clk);
    addr <= {idx, chip};
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [31:0] v);
    @(posedge clk);
    addr <= {idx, chip};
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  // control word, crystal rate always chosen and vco running
  function automatic logic [31:0] ctl(logic [1:0] amp, logic [1:0] dv, logic [2:0] is,
    logic src);
    ctl = 32'h3 | (32'(amp) << AMP_OP_LSB) | (32'(dv) << XDIV_LSB)
      | (32'(is) << IN_SEL_LSB) | (32'(src) << CLK_SRC_BIT);
  endfunction
  // one clock source case: lock level, control word, expected source and lock
  task automatic src_case(input logic lk, input logic [31:0] w, input logic es,
    input logic el);
    @(posedge clk);
    lock_req <= lk;
    wr(REG_CTRL, w);
    cyc(80);
    chk(src_xtal, es);
    chk(lock_err, !el);
    rd(REG_STATUS, d);
    chk(d[1:0], {es, el});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog, far above the thousand or so cycles the tests need
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  // ==========================================
  // tests
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // two strap sets; straps then move and must be ignored
    for (int c = 0; c < 2; c++) begin
      sys_n <= 1'b0;
      a_lo <= c[0];
      a_hi <= !c[0];
      role <= !c[0];
      gdir <= !c[0];
      chip = {!c[0], c[0]};
      cyc(8);
      sys_n <= 1'b1;
      cyc(3);
      a_lo <= !c[0];
      role <= c[0];
      gdir <= c[0];
      cyc(3);
      chk(bck_oe, c[0]);
      chk(lrck_oe, c[0]);
      chk(mck_oe, 1'b1);
      chk(gpio_oe, {4{!c[0]}});
      rd(REG_STATUS, d);
      chk(d[10:7], {chip, !c[0], !c[0]});
      rd(REG_CTRL, d);
      chk(d, 32'(CTRL_RESET));
      $display("test straps %0d done", c);
    end
    // foreign chip addresses are refused, writes and reads alike
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        chip = k[1:0];
        wr(REG_CTRL, ctl(AMP_CONT, XDIV_1, 3'h0, 1'b1));
        rd(REG_CTRL, d);
        chk(d, 32'h0);
        chip = 2'h1;
        rd(REG_CTRL, d);
        chk(d, 32'(CTRL_RESET));
      end
    end
    rd(4'h3, d);
    chk(d, 32'h0);
    $display("test address done");
    // crystal rate set before frames start
    wr(REG_CTRL, ctl(AMP_CONT, XDIV_1, 3'h0, 1'b0));
    frames_on <= 1'b1;
    src_case(1'b1, ctl(AMP_CONT, XDIV_1, 3'h0, 1'b0), 1'b0, 1'b1);
    src_case(1'b1, ctl(AMP_CONT, XDIV_1, 3'h0, 1'b1), 1'b1, 1'b1);
    src_case(1'b0, ctl(AMP_CONT, XDIV_1, 3'h0, 1'b0), 1'b1, 1'b0);
    src_case(1'b1, ctl(AMP_CONT, XDIV_1, IN_NONE, 1'b0), 1'b1, 1'b0);
    src_case(1'b1, ctl(AMP_CONT, XDIV_1, 3'h0, 1'b0) & ~32'h1, 1'b1, 1'b0);
    chk(vco_run, 1'b0);
    $display("test source done");
    // auto stop while locked, then forced crystal with continuous amplifier
    wr(REG_CTRL, ctl(AMP_AUTO, XDIV_1, 3'h0, 1'b0));
    cyc(40);
    chk(amp_run, 1'b0);
    wr(REG_CTRL, ctl(AMP_CONT, XDIV_1, 3'h0, 1'b1));
    cyc(4);
    chk(amp_run, 1'b1);
    chk(clk_mute, 1'b0);
    chk(lock_err, 1'b1);
    cyc(100);
    chk(lock_err, 1'b0);
    rd(REG_FS_PERIOD, d);
    chk(d, 32'h0000000f);
    wr(REG_CTRL, ctl(2'h2, XDIV_1, 3'h0, 1'b1));
    cyc(4);
    chk(clk_mute, 1'b1);
    $display("test amplifier done");
    // divider ratios counted as output transitions over 64 clocks
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, ctl(AMP_CONT, r[1:0], 3'h0, 1'b1));
      cyc(30);
      n = 0;
      prev = xtal_out;
      repeat (64) begin
        @(posedge clk);
        #1;
        n += (xtal_out !== prev);
        prev = xtal_out;
      end
      chk(n, (r == 3) ? 0 : (64 >> r));
    end
    $display("test divider done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
